//--- core/cmg_pkg.sv
/*
  package for the configuration memory access gate: region codes, fuse
  layout, delivery values and gate sizes.
  assumes: included ahead of core/cmg_gate.sv.
*/
package cmg_pkg;

  // ----------------------------------------------------------------------
  // regions of the configuration memory
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    CMG_RG_ANTICOLL = 4'h0,
    CMG_RG_TEST = 4'h1,
    CMG_RG_HW_REV = 4'h2,
    CMG_RG_SERIAL = 4'h3,
    CMG_RG_ACCESS = 4'h4,
    CMG_RG_DEVCFG = 4'h5,
    CMG_RG_CRYPTO = 4'h6,
    CMG_RG_KEYS = 4'h7,
    CMG_RG_SECRET = 4'h8,
    CMG_RG_PASSWORD = 4'h9,
    CMG_RG_ATTEMPT = 4'hA,
    CMG_RG_FORBIDDEN = 4'hB
  } cmg_region_t;

  // ----------------------------------------------------------------------
  // fuse byte layout and values
  // ----------------------------------------------------------------------
  localparam int CMG_FUSE_PERS_BIT = 0;
  localparam int CMG_FUSE_KEYLOCK_BIT = 1;
  localparam int CMG_FUSE_ENCR_BIT = 2;
  localparam int CMG_FUSE_FACT_BIT = 3;
  // delivery state: factory fuse 0, others 1
  localparam logic [3:0] CMG_FUSE_RESET = 4'h7;
  localparam int CMG_PW_SETS = 8;
  localparam int CMG_PW_SET_W = 3;
  localparam int CMG_ZONES = 16;

endpackage

//--- core/cmg_gate.sv
/*
  configuration memory access gate: decides each read or write of the
  configuration memory from the fuses and the validated credentials.
  assumes: request and credential strobes come from command logic on
  ref_clk; fuse state is held here and lost on power-on reset only in
  this model (nonvolatile storage lies outside).
*/
//
// How it works
// [R1] transport-restricted regions open only after a valid transport password check
// [R2] a write password unlocks only its own set's counters and passwords
// [R3] die serial number always readable, never writable
// [R4] crypto registers readable; write needs transport while key-lock fuse is 1
// [R5] after encryption fuse and until key-lock fuse, keys/secrets/passwords writes need transport plus encryption
// [R6] one access register per user zone plus a device configuration register
// [R7] fuses program only encryption, then key-lock, then personalization
// [R8] delivery state: factory fuse 0, other three fuses 1
// [R9] memory test zone always open; forbidden region always refused
`timescale 1ns/100ps
module cmg_gate
  import cmg_pkg::*;
#(
  parameter int ZONES = cmg_pkg::CMG_ZONES,
  parameter int PW_SETS = cmg_pkg::CMG_PW_SETS
)
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic req_valid,
  input wire logic req_write,
  input wire cmg_pkg::cmg_region_t req_region,
  input wire logic [cmg_pkg::CMG_PW_SET_W-1:0] req_pw_set,
  input wire logic [3:0] req_zone,
  input wire logic [7:0] req_data,
  input wire logic transport_ok,
  input wire logic write_credential_ok,
  input wire logic [cmg_pkg::CMG_PW_SET_W-1:0] write_credential_set,
  input wire logic cred_clear,
  input wire logic encryption_active,
  input wire logic fuse_prog,
  input wire logic [1:0] fuse_sel,
  output logic grant_ff,
  output logic deny_ff,
  output logic fuse_ack_ff,
  output logic fuse_nak_ff,
  output logic [3:0] fuse_state_ff,
  output logic [7:0] zone_access_ff,
  output logic [7:0] device_config_ff
);
  import cmg_pkg::*;

  // ----------------------------------------------------------------------
  // credential and fuse state
  // ----------------------------------------------------------------------
  logic [3:0] fuse_q_ff, nxt_fuse_q;
  logic transport_cred_ff, nxt_transport_cred;
  logic [PW_SETS-1:0] write_cred_ff, nxt_write_cred;
  logic fuse_ack_nxt, fuse_nak_nxt;
  logic enc_f, key_f, per_f;

  assign enc_f = fuse_q_ff[CMG_FUSE_ENCR_BIT];
  assign key_f = fuse_q_ff[CMG_FUSE_KEYLOCK_BIT];
  assign per_f = fuse_q_ff[CMG_FUSE_PERS_BIT];

  always_comb
  begin
    nxt_transport_cred = transport_cred_ff;
    nxt_write_cred = write_cred_ff;
    if (cred_clear)
    begin
      nxt_transport_cred = 1'b0;
      nxt_write_cred = '0;
    end
    // [R1] transport check latch
    if (transport_ok)
      nxt_transport_cred = 1'b1;
    // [R2] per-set unlock
    if (write_credential_ok)
      nxt_write_cred[write_credential_set] = 1'b1;
  end

  // fuse_sel: 0 encryption, 1 key-lock, 2 personalization
  always_comb
  begin
    nxt_fuse_q = fuse_q_ff;
    fuse_ack_nxt = 1'b0;
    fuse_nak_nxt = 1'b0;
    if (fuse_prog)
    begin
      // [R7] enforce programming order
      if (fuse_sel == 2'd0 && enc_f)
      begin
        nxt_fuse_q[CMG_FUSE_ENCR_BIT] = 1'b0;
        fuse_ack_nxt = 1'b1;
      end
      else if (fuse_sel == 2'd1 && !enc_f && key_f)
      begin
        nxt_fuse_q[CMG_FUSE_KEYLOCK_BIT] = 1'b0;
        fuse_ack_nxt = 1'b1;
      end
      else if (fuse_sel == 2'd2 && !key_f && per_f)
      begin
        nxt_fuse_q[CMG_FUSE_PERS_BIT] = 1'b0;
        fuse_ack_nxt = 1'b1;
      end
      else
        fuse_nak_nxt = 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // access decision
  // ----------------------------------------------------------------------
  logic allow;
  logic own_set;
  logic tp_enc;

  always_comb
  begin
    own_set = write_cred_ff[req_pw_set];
    // stage two: encryption fuse blown, key-lock still intact
    tp_enc = transport_cred_ff && (enc_f || encryption_active);
    allow = 1'b0;
    case (req_region)
      // [R9] test zone open
      CMG_RG_TEST: allow = 1'b1;
      CMG_RG_HW_REV: allow = !req_write;
      // [R3] serial read only
      CMG_RG_SERIAL: allow = !req_write;
      CMG_RG_ANTICOLL, CMG_RG_ACCESS:
        allow = !req_write || (per_f && transport_cred_ff);
      // [R4] crypto write gated by key-lock
      CMG_RG_DEVCFG, CMG_RG_CRYPTO:
        allow = !req_write || (key_f && transport_cred_ff);
      // [R5] keys and secrets writes need encryption after first fuse
      CMG_RG_KEYS, CMG_RG_SECRET:
        allow = key_f && (req_write ? tp_enc : transport_cred_ff);
      CMG_RG_PASSWORD:
        if (!per_f)
          // [R2] own password set only
          allow = own_set;
        else if (key_f && req_write)
          allow = tp_enc;
        else
          allow = transport_cred_ff;
      CMG_RG_ATTEMPT:
        if (!req_write)
          allow = 1'b1;
        else if (!per_f)
          allow = own_set;
        else
          allow = transport_cred_ff;
      // [R9] forbidden region refused
      CMG_RG_FORBIDDEN: allow = 1'b0;
      default: allow = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------------
  // zone access and device configuration registers
  // ----------------------------------------------------------------------
  logic [7:0] zone_ar_ff [ZONES];
  logic [7:0] nxt_zone_ar [ZONES];
  logic [7:0] nxt_devcfg;
  logic wr_ok;

  assign wr_ok = req_valid && req_write && allow;

  // [R6] one access register per zone
  genvar gz;
  generate
    for (gz = 0; gz < ZONES; gz++)
    begin : g_zone
      always_comb
      begin
        nxt_zone_ar[gz] = zone_ar_ff[gz];
        if (wr_ok && req_region == CMG_RG_ACCESS && req_zone == 4'(gz))
          nxt_zone_ar[gz] = req_data;
      end
      always_ff @(posedge ref_clk or negedge rst_n)
      begin
        if (!rst_n)
          zone_ar_ff[gz] <= 8'hFF;
        else
          zone_ar_ff[gz] <= nxt_zone_ar[gz];
      end
    end
  endgenerate

  always_comb
  begin
    nxt_devcfg = device_config_ff;
    // [R6] device configuration register
    if (wr_ok && req_region == CMG_RG_DEVCFG)
      nxt_devcfg = req_data;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      // [R8] delivery fuse state
      fuse_q_ff <= CMG_FUSE_RESET;
      fuse_state_ff <= CMG_FUSE_RESET;
      transport_cred_ff <= 1'b0;
      write_cred_ff <= '0;
      grant_ff <= 1'b0;
      deny_ff <= 1'b0;
      fuse_ack_ff <= 1'b0;
      fuse_nak_ff <= 1'b0;
      zone_access_ff <= 8'hFF;
      device_config_ff <= 8'hFF;
    end
    else
    begin
      fuse_q_ff <= nxt_fuse_q;
      fuse_state_ff <= nxt_fuse_q;
      transport_cred_ff <= nxt_transport_cred;
      write_cred_ff <= nxt_write_cred;
      grant_ff <= req_valid && allow;
      deny_ff <= req_valid && !allow;
      fuse_ack_ff <= fuse_ack_nxt;
      fuse_nak_ff <= fuse_nak_nxt;
      zone_access_ff <= nxt_zone_ar[req_zone];
      device_config_ff <= nxt_devcfg;
    end
  end

endmodule // cmg_gate

//--- tb/cmg_gate_checker.sv
/* port checker for cmg_gate; assumes a bind from the bench */
`timescale 1ns/100ps
module cmg_gate_checker
  import cmg_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic req_valid,
  input wire logic req_write,
  input wire cmg_region_t req_region,
  input wire logic fuse_prog,
  input wire logic grant_ff,
  input wire logic deny_ff,
  input wire logic fuse_ack_ff,
  input wire logic fuse_nak_ff,
  input wire logic [3:0] fuse_state_ff
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  a_one_answer: assert property (req_valid |=> grant_ff != deny_ff)
    else $error("no answer");
  a_idle_quiet: assert property (!req_valid |=> !grant_ff && !deny_ff)
    else $error("stray answer");
  a_test_open: assert property (req_valid && req_region == CMG_RG_TEST |=> grant_ff)
    else $error("test zone");
  a_forbid_deny: assert property (req_valid && req_region == CMG_RG_FORBIDDEN |=> deny_ff)
    else $error("forbidden");
  a_fuse_answer: assert property (fuse_prog |=> fuse_ack_ff != fuse_nak_ff)
    else $error("fuse answer");
  a_fuse_idle: assert property (!fuse_prog |=> !fuse_ack_ff && !fuse_nak_ff)
    else $error("stray fuse");
  a_fuse_change: assert property ($changed(fuse_state_ff) |-> fuse_ack_ff)
    else $error("fuse change");
  a_factory_fuse: assert property (!fuse_state_ff[3])
    else $error("factory fuse");
  a_serial_ro: assert property (req_valid && req_write && req_region == CMG_RG_SERIAL |=> deny_ff)
    else $error("serial write");
endmodule // cmg_gate_checker

//--- tb/cmg_reader.sv
/* reader model; assumes the bench calls cmd */
`timescale 1ns/100ps
module cmg_reader
  import cmg_pkg::*;
(
  input wire logic ref_clk,
  output logic req_valid,
  output logic req_write,
  output cmg_region_t req_region,
  output logic [2:0] req_pw_set,
  output logic [3:0] req_zone,
  output logic [7:0] req_data,
  output logic transport_ok,
  output logic write_credential_ok,
  output logic [2:0] write_credential_set,
  output logic cred_clear,
  output logic encryption_active,
  output logic fuse_prog,
  output logic [1:0] fuse_sel
);
  initial
  begin
    {req_valid, req_write, req_pw_set, req_zone, req_data, fuse_sel, fuse_prog} = '0;
    {transport_ok, write_credential_ok, write_credential_set, cred_clear, encryption_active} = '0;
    req_region = CMG_RG_TEST;
  end
  task cmd(input bit fz, w, t, p, e, input int r, input logic [17:0] v);
    @(posedge ref_clk);
    {cred_clear, transport_ok, write_credential_ok} <= {1'h1, t, p};
    {write_credential_set, encryption_active} <= {v[10:8], e};
    @(posedge ref_clk);
    // checks land one edge before use
    {cred_clear, transport_ok, write_credential_ok} <= '0;
    {req_valid, fuse_prog, req_write, fuse_sel} <= {!fz, fz, w, r[1:0]};
    {req_zone, req_pw_set, req_data} <= {v[17:14], v[13:11], v[7:0]};
    req_region <= cmg_region_t'(r);
    @(posedge ref_clk);
    {req_valid, fuse_prog} <= '0;
    @(negedge ref_clk);
  endtask
endmodule // cmg_reader

//--- tb/test_config_memory_access_gate.sv
/* random commands against a table model; assumes cmg_gate, cmg_reader */
`timescale 1ns/100ps
module test_config_memory_access_gate;
  import cmg_pkg::*;
  logic ref_clk = 0, rst_n = 0, req_valid, req_write, transport_ok, write_credential_ok, cred_clear;
  logic encryption_active, fuse_prog, grant_ff, deny_ff, fuse_ack_ff, fuse_nak_ff, w, t, e, p, g;
  cmg_region_t req_region;
  logic [2:0] req_pw_set, write_credential_set, ps;
  logic [3:0] req_zone, fuse_state_ff, z, f = 4'h7;
  logic [7:0] req_data, zone_access_ff, device_config_ff, d;
  logic [1:0] fuse_sel;
  // model copies of the zone access registers and the device config register
  logic [7:0] zm [16];
  logic [7:0] dm;
  logic hit;
  int fails = 0, cmp_count = 0, s, r, k;
  cmg_gate i_cmg_gate (
    .ref_clk(ref_clk), .rst_n(rst_n), .req_valid(req_valid), .req_write(req_write),
    .req_region(req_region), .req_pw_set(req_pw_set), .req_zone(req_zone),
    .req_data(req_data), .transport_ok(transport_ok), .write_credential_ok(write_credential_ok),
    .write_credential_set(write_credential_set), .cred_clear(cred_clear),
    .encryption_active(encryption_active), .fuse_prog(fuse_prog), .fuse_sel(fuse_sel),
    .grant_ff(grant_ff), .deny_ff(deny_ff), .fuse_ack_ff(fuse_ack_ff),
    .fuse_nak_ff(fuse_nak_ff), .fuse_state_ff(fuse_state_ff),
    .zone_access_ff(zone_access_ff), .device_config_ff(device_config_ff)
  );
  cmg_reader i_cmg_reader (
    .ref_clk(ref_clk), .req_valid(req_valid), .req_write(req_write),
    .req_region(req_region), .req_pw_set(req_pw_set), .req_zone(req_zone),
    .req_data(req_data), .transport_ok(transport_ok), .write_credential_ok(write_credential_ok),
    .write_credential_set(write_credential_set), .cred_clear(cred_clear),
    .encryption_active(encryption_active), .fuse_prog(fuse_prog), .fuse_sel(fuse_sel)
  );
  initial forever #20 ref_clk = ~ref_clk;
  task chk(input logic [19:0] a, b);
    cmp_count++;
    if (a !== b)
      $display("wrong value at %0t: %h not %h", $time, a, b);
    fails += int'(a !== b);
  endtask
  task summarize();
    $display("fails %0d of %0d", fails, cmp_count);
    if (fails == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  function bit ok(int s, r, bit w, t, e, p);
    case (r)
      1: return 1;
      2, 3: return !w;
      0, 4: return !w || (t && s < 4);
      5, 6: return !w || (t && s < 3);
      7, 8: return s < 3 && t && (!w || s < 2 || e);
      9: return s < 4 ? t && (!w || s != 2 || e) : p;
      10: return !w || (s < 4 ? t : p);
      default: return 0;
    endcase
  endfunction
  initial
  begin
    void'($urandom(32'hde85));
    foreach (zm[i])
      zm[i] = 8'hff;
    dm = 8'hff;
    repeat (16) @(posedge ref_clk);
    rst_n <= 1;
    @(negedge ref_clk);
    chk({fuse_state_ff, zone_access_ff, device_config_ff}, {f, 16'hffff});
    for (s = 1; s < 5; s++)
    begin
      repeat (64)
      begin
        {w, t, e, p, g, z, ps, d} = 20'($urandom);
        r = $urandom_range(11);
        // g picks the own set or a foreign one
        i_cmg_reader.cmd(0, w, t, p, e, r, {z, ps, g ? ps : ps + 3'h1, d});
        g = ok(s, r, w, t, e, p && g);
        chk({grant_ff, deny_ff}, {g, !g});
        if (w && g && r == 4)
          zm[z] = d;
        if (w && g && r == 5)
          dm = d;
        chk({zone_access_ff, device_config_ff}, {zm[z], dm});
      end
      for (k = 3; k >= 0; k--)
      begin
        i_cmg_reader.cmd(1, 0, 0, 0, e, k, 0);
        // select 3 names no fuse, and once all three are blown every attempt is refused
        hit = k == s - 1 && s < 4;
        if (hit)
          f[2 - k] = 0;
        chk({fuse_ack_ff, fuse_nak_ff, fuse_state_ff}, {hit, !hit, f});
      end
    end
    summarize();
  end
endmodule // test_config_memory_access_gate
bind cmg_gate cmg_gate_checker i_cmg_gate_checker (
  .ref_clk(ref_clk), .rst_n(rst_n), .req_valid(req_valid), .req_write(req_write),
  .req_region(req_region), .fuse_prog(fuse_prog), .grant_ff(grant_ff), .deny_ff(deny_ff),
  .fuse_ack_ff(fuse_ack_ff), .fuse_nak_ff(fuse_nak_ff), .fuse_state_ff(fuse_state_ff)
);
